// [hw/nvp_cfg.svh]
// constants of the nonvolatile byte access port
`ifndef NVP_CFG_SVH
`define NVP_CFG_SVH
`define NVP_DEPTH          1024
`define NVP_AW             10
`define NVP_IO_AW          6
`define NVP_IO_ADDR_HIGH   6'h1f
`define NVP_IO_ADDR_LOW    6'h1e
`define NVP_IO_BUFFER      6'h1d
`define NVP_IO_CONTROL     6'h1c
`define NVP_CTRL_READ      0
`define NVP_CTRL_WSTB      1
`define NVP_CTRL_ARM       2
`define NVP_HIGH_BITS      2
`define NVP_ARM_CYCLES     3'h4
`define NVP_READ_STALL     3'h4
`define NVP_WRITE_STALL    3'h2
`define NVP_OSC_CYCLES     8448
`define NVP_OSC_PERIOD_NS  1000
`define NVP_CLK_PERIOD_NS  4
`define NVP_TIMER_W        22
`endif

// [hw/nvp_pkg.sv]
// types of the nonvolatile byte access port
package nvp_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } nvp_io_req_t;
  typedef enum logic {NVP_IDLE, NVP_PROG} nvp_state_t;
endpackage

// [hw/nvp_port.sv]
// core-side access port to the 1024-byte nonvolatile data store
`timescale 1ns/1ps
`include "nvp_cfg.svh"

module nvp_port
  import nvp_pkg::*;
#(
  parameter logic [`NVP_TIMER_W-1:0] WRITE_CYCLES =
    `NVP_TIMER_W'(`NVP_OSC_CYCLES * `NVP_OSC_PERIOD_NS / `NVP_CLK_PERIOD_NS)
) (
  input  wire logic        sys_clk,     // core clock
  input  wire logic        reset,       // synchronous, active high
  input  wire nvp_io_req_t io_req,      // I/O register access from the core
  output logic [7:0]       io_rdata,    // read data, one cycle after io_req.rd
  output logic             core_stall,  // hold the core
  output logic             write_busy   // programming in progress
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]             mem [`NVP_DEPTH];
  logic [`NVP_AW-1:0]     nv_byte_address_reg;
  logic [7:0]             nv_byte_buffer_reg;
  logic                   write_arm_reg;
  logic [2:0]             arm_cnt_reg;
  logic [2:0]             stall_cnt_reg;
  logic [2:0]             stall_cnt_next;
  logic                   core_stall_reg;
  logic [7:0]             io_rdata_reg;
  logic [`NVP_TIMER_W-1:0] prog_cnt_reg;
  nvp_state_t             state_reg;
  logic                   busy;
  logic                   ctrl_wr;
  logic                   read_go;
  logic                   write_go;
  logic                   arm_set;

  assign busy     = (state_reg == NVP_PROG);
  assign ctrl_wr  = io_req.wr && (io_req.addr == `NVP_IO_CONTROL);
  assign arm_set  = ctrl_wr && io_req.wdata[`NVP_CTRL_ARM];
  // a read is refused while programming
  assign read_go  = ctrl_wr && io_req.wdata[`NVP_CTRL_READ] && !busy;
  // strobe only counts inside the arm window
  assign write_go = ctrl_wr && io_req.wdata[`NVP_CTRL_WSTB] && write_arm_reg
                    && !busy;

  ////////////////////////////////////////////////////////////////////////
  // address, frozen while a write is running
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_byte_address_reg <= '0;
    end else if (io_req.wr && !busy) begin
      if (io_req.addr == `NVP_IO_ADDR_HIGH) begin
        nv_byte_address_reg[`NVP_AW-1:8] <= io_req.wdata[`NVP_HIGH_BITS-1:0];
      end else if (io_req.addr == `NVP_IO_ADDR_LOW) begin
        nv_byte_address_reg[7:0] <= io_req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_byte_buffer_reg <= '0;
    end else if (read_go) begin
      nv_byte_buffer_reg <= mem[nv_byte_address_reg];
    end else if (io_req.wr && io_req.addr == `NVP_IO_BUFFER) begin
      nv_byte_buffer_reg <= io_req.wdata;
    end
  end

  // array is written at the trigger; reads stay blocked until the timer ends
  always_ff @(posedge sys_clk) begin
    if (write_go) begin
      mem[nv_byte_address_reg] <= nv_byte_buffer_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      write_arm_reg <= 1'b0;
      arm_cnt_reg   <= '0;
    end else if (arm_set) begin
      write_arm_reg <= 1'b1;
      arm_cnt_reg   <= `NVP_ARM_CYCLES;
    end else if (arm_cnt_reg != 3'h0) begin
      arm_cnt_reg   <= arm_cnt_reg - 3'h1;
      if (arm_cnt_reg == 3'h1) begin
        write_arm_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg    <= NVP_IDLE;
      prog_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        NVP_IDLE: begin
          if (write_go) begin
            state_reg    <= NVP_PROG;
            prog_cnt_reg <= WRITE_CYCLES;
          end
        end
        NVP_PROG: begin
          if (prog_cnt_reg <= `NVP_TIMER_W'(1)) begin
            state_reg <= NVP_IDLE;
          end
          prog_cnt_reg <= prog_cnt_reg - `NVP_TIMER_W'(1);
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (read_go) begin
      stall_cnt_next = `NVP_READ_STALL;
    end else if (write_go) begin
      stall_cnt_next = `NVP_WRITE_STALL;
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_next = stall_cnt_reg - 3'h1;
    end else begin
      stall_cnt_next = 3'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stall_cnt_reg  <= '0;
      core_stall_reg <= 1'b0;
    end else begin
      stall_cnt_reg  <= stall_cnt_next;
      core_stall_reg <= (stall_cnt_next != 3'h0);
    end
  end

  // arm and write strobe bits read back live state; the read strobe always reads zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      io_rdata_reg <= '0;
    end else if (io_req.rd) begin
      unique case (io_req.addr)
        `NVP_IO_ADDR_HIGH: io_rdata_reg <= 8'(nv_byte_address_reg[`NVP_AW-1:8]);
        `NVP_IO_ADDR_LOW:  io_rdata_reg <= nv_byte_address_reg[7:0];
        `NVP_IO_BUFFER:    io_rdata_reg <= nv_byte_buffer_reg;
        `NVP_IO_CONTROL:   io_rdata_reg <= {5'h00, write_arm_reg, busy, 1'b0};
        default:           io_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign io_rdata   = io_rdata_reg;
  assign core_stall = core_stall_reg;
  assign write_busy = (state_reg == NVP_PROG);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_read_stall_len: assert property (read_go |=> core_stall [*4] ##1 !core_stall)
    else $error("read stall is not four cycles");
  a_write_stall_len: assert property (write_go |=> core_stall [*2] ##1 !core_stall)
    else $error("write stall is not two cycles");
  // a fresh arm write restarts the window, so only an untouched window must lapse
  a_arm_timeout: assert property ($rose(write_arm_reg) ##0 !arm_set [*4]
      |=> !write_arm_reg)
    else $error("arm bit did not clear after four cycles");
  a_arm_holds: assert property ($rose(write_arm_reg) |-> write_arm_reg [*4])
    else $error("arm bit cleared too early");
  a_strobe_needs_arm: assert property (ctrl_wr && io_req.wdata[`NVP_CTRL_WSTB]
      && !write_arm_reg && !busy |=> !busy)
    else $error("write started without arm");
  a_write_starts: assert property (write_go |=> busy && core_stall)
    else $error("armed strobe did not start a write");
  a_addr_frozen: assert property (busy |=> $stable(nv_byte_address_reg))
    else $error("address changed during programming");
  a_read_blocked: assert property (busy && ctrl_wr |=> $stable(nv_byte_buffer_reg)
      || $past(io_req.addr) == `NVP_IO_BUFFER)
    else $error("read trigger acted during programming");
  a_read_data: assert property (read_go
      |=> nv_byte_buffer_reg == mem[$past(nv_byte_address_reg)])
    else $error("buffer not loaded from addressed byte");
  a_high_zero: assert property (io_req.rd && io_req.addr == `NVP_IO_ADDR_HIGH
      |=> io_rdata[7:`NVP_HIGH_BITS] == 6'h00)
    else $error("unused address bits read nonzero");
  a_addr_load: assert property (io_req.wr && io_req.addr == `NVP_IO_ADDR_LOW && !busy
      |=> nv_byte_address_reg[7:0] == $past(io_req.wdata))
    else $error("low address byte not loaded");
  // buffer stays writable while busy; the running write already holds its byte
  a_buffer_load: assert property (io_req.wr && io_req.addr == `NVP_IO_BUFFER
      |=> nv_byte_buffer_reg == $past(io_req.wdata))
    else $error("byte buffer not loaded");
  a_write_stores: assert property (write_go |=> mem[$past(nv_byte_address_reg)]
      == $past(nv_byte_buffer_reg))
    else $error("byte not programmed");
  a_timer_ends: assert property (busy && prog_cnt_reg == `NVP_TIMER_W'(1) |=> !busy)
    else $error("busy did not end with the timer");
  a_busy_bit: assert property (io_req.rd && io_req.addr == `NVP_IO_CONTROL
      |=> io_rdata[`NVP_CTRL_WSTB] == $past(busy))
    else $error("write strobe bit does not show busy");

  // strobe on the last edge of the arm window must still start a write
  c_read:       cover property (read_go ##5 !core_stall);
  c_write:      cover property (write_go ##1 busy ##[1:1000] !busy);
  c_arm_lapse:  cover property ($rose(write_arm_reg) ##4 !write_arm_reg);
  c_busy_read:  cover property (busy && ctrl_wr && io_req.wdata[`NVP_CTRL_READ]);
  c_arm_edge:   cover property ($rose(write_arm_reg) ##3 write_go);

endmodule

// [testbench/nvp_core_model.sv]
// core model issuing I/O register accesses to the port
`timescale 1ns/1ps
`include "nvp_cfg.svh"
module nvp_core_model
  import nvp_pkg::*;
(
  input  wire logic        sys_clk,    // core clock
  input  wire logic        core_stall, // port holds the core
  input  wire logic [7:0]  io_rdata,   // read data from the port
  output nvp_io_req_t      io_req      // access towards the port
);
  int hangs = 0;  // accesses issued after the stall wait ran out
  initial io_req = '0;
  //////////////////////////////////////////////////////////////////////////////
  // a real core issues nothing while halted
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    for (int i = 0; i < 8 && core_stall === 1'b1; i++) @(posedge sys_clk);
    if (core_stall === 1'b1) hangs++;
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    io_req <= '0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    for (int i = 0; i < 8 && core_stall === 1'b1; i++) @(posedge sys_clk);
    if (core_stall === 1'b1) hangs++;
    io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    io_req <= '0;
    #1 d = io_rdata;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic set_addr(input logic [9:0] a);
    wr(`NVP_IO_ADDR_HIGH, {6'h00, a[9:8]});
    wr(`NVP_IO_ADDR_LOW, a[7:0]);
  endtask
  task automatic write_byte(input logic [9:0] a, input logic [7:0] d);
    set_addr(a);
    wr(`NVP_IO_BUFFER, d);
    wr(`NVP_IO_CONTROL, 8'h04);
    wr(`NVP_IO_CONTROL, 8'h02);
  endtask
  task automatic read_byte(input logic [9:0] a);
    set_addr(a);
    wr(`NVP_IO_CONTROL, 8'h01);
  endtask
endmodule

// [testbench/nvp_port_tb_top.sv]
// self-checking bench of the nonvolatile byte access port
`timescale 1ns/1ps
`include "nvp_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module nvp_port_tb_top;
  import nvp_pkg::*;
  localparam int WCYC = 20; // short write time keeps the run brief
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        core_stall;
  logic        write_busy;
  logic [7:0]  io_rdata;
  logic [7:0]  d;
  nvp_io_req_t io_req;
  int          errors = 0;
  int          n_checks = 0;
  int          n;
  logic [15:0] lfsr = 16'h0038;
  logic [9:0]  a;
  logic [9:0]  q [$];
  logic [7:0]  mem [logic [9:0]];
  initial forever #2 sys_clk = ~sys_clk;
  nvp_port #(.WRITE_CYCLES(`NVP_TIMER_W'(WCYC))) u_dut (.sys_clk(sys_clk), .reset(reset),
    .io_req(io_req), .io_rdata(io_rdata), .core_stall(core_stall), .write_busy(write_busy));
  nvp_core_model u_core (.sys_clk(sys_clk), .core_stall(core_stall), .io_rdata(io_rdata),
    .io_req(io_req));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] ctrl_expect(input logic arm, input logic bsy);
    return {5'h00, arm, bsy, 1'b0};
  endfunction
  task automatic summarize();
    errors = errors + u_core.hangs;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic stall_len(input int e);
    n = 0;
    #1;
    while (core_stall === 1'b1 && n < 9) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    `CHK(n, e)
  endtask
  task automatic wait_idle();
    for (n = 0; n < WCYC + 20 && write_busy !== 1'b0; n++) @(posedge sys_clk);
    if (write_busy !== 1'b0) begin
      errors++;
      $display("[ERR] %0t busy never ended", $time);
      summarize();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    u_core.rd(`NVP_IO_ADDR_LOW, d);
    `CHK(d, 8'h00)
    u_core.rd(6'h00, d);
    `CHK(d, 8'h00)
    u_core.wr(`NVP_IO_ADDR_HIGH, 8'hff);
    u_core.rd(`NVP_IO_ADDR_HIGH, d);
    `CHK(d, 8'h03)
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : lfsr[9:0]; // ends of the space first
      mem[a] = lfsr[15:8];
      q.push_back(a);
      u_core.write_byte(a, lfsr[15:8]);
      stall_len(2);
      u_core.rd(`NVP_IO_CONTROL, d);
      `CHK(d, ctrl_expect(1'b0, 1'b1))
      wait_idle();
    end
    foreach (q[i]) begin
      u_core.read_byte(q[i]);
      stall_len(4);
      u_core.rd(`NVP_IO_BUFFER, d);
      `CHK(d, mem[q[i]])
    end
    $display("test write read done");
    u_core.wr(`NVP_IO_CONTROL, 8'h02);
    #1 `CHK(write_busy, 1'b0)
    u_core.wr(`NVP_IO_CONTROL, 8'h06); // arm in the same write does not count
    #1 `CHK(write_busy, 1'b0)
    u_core.rd(`NVP_IO_CONTROL, d);
    `CHK(d, ctrl_expect(1'b1, 1'b0))
    u_core.wr(`NVP_IO_CONTROL, 8'h04);
    repeat (3) @(posedge sys_clk); // strobe lands one edge past the window
    u_core.wr(`NVP_IO_CONTROL, 8'h02);
    #1 `CHK(write_busy, 1'b0)
    $display("test refusals done");
    u_core.set_addr(q[2]);
    u_core.wr(`NVP_IO_BUFFER, 8'h5a);
    u_core.wr(`NVP_IO_CONTROL, 8'h04);
    repeat (2) @(posedge sys_clk); // strobe on the last edge of the window
    u_core.wr(`NVP_IO_CONTROL, 8'h02);
    #1 `CHK(write_busy, 1'b1)
    u_core.wr(`NVP_IO_BUFFER, 8'ha5); // a read that slipped through would overwrite this
    u_core.wr(`NVP_IO_ADDR_LOW, ~q[2][7:0]);
    u_core.wr(`NVP_IO_CONTROL, 8'h01);
    wait_idle();
    u_core.rd(`NVP_IO_ADDR_LOW, d);
    `CHK(d, q[2][7:0])
    u_core.rd(`NVP_IO_BUFFER, d);
    `CHK(d, 8'ha5)
    u_core.read_byte(q[2]);
    stall_len(4);
    u_core.rd(`NVP_IO_BUFFER, d);
    `CHK(d, 8'h5a)
    $display("test busy blocking done");
    summarize();
  end
endmodule
